// file: core/nvsram_ctrl_params.svh
`ifndef NVSRAM_CTRL_PARAMS_SVH
`define NVSRAM_CTRL_PARAMS_SVH

`define NV_CLK_PERIOD_PS      25000
`define NV_ADDR_W             15
`define NV_DATA_W             8
`define NV_SEQ_LEN            6
`define NV_SEQ_MASK           15'h3FFF
`define NV_SEQ_A0             15'h0E38
`define NV_SEQ_A1             15'h31C7
`define NV_SEQ_A2             15'h03E0
`define NV_SEQ_A3             15'h3C1F
`define NV_SEQ_A4             15'h303F
`define NV_SEQ_STORE          15'h0FC0
`define NV_SEQ_RECALL         15'h0C63
// times in ps, cycle counts derived from the 25 ns clock
`define NV_SETUP_PS           25000
`define NV_SETUP_CYC          ((`NV_SETUP_PS + `NV_CLK_PERIOD_PS - 1) / `NV_CLK_PERIOD_PS)
`define NV_STROBE_PS          50000
`define NV_STROBE_CYC         ((`NV_STROBE_PS + `NV_CLK_PERIOD_PS - 1) / `NV_CLK_PERIOD_PS)
`define NV_HSB_PULSE_PS       15000
`define NV_HSB_PULSE_CYC      ((`NV_HSB_PULSE_PS + `NV_CLK_PERIOD_PS - 1) / `NV_CLK_PERIOD_PS)
`define NV_BUSY_WAIT_PS       300000
`define NV_BUSY_WAIT_CYC      (`NV_BUSY_WAIT_PS / `NV_CLK_PERIOD_PS)
`define NV_GRACE_PS           1000000
`define NV_GRACE_CYC          ((`NV_GRACE_PS + `NV_CLK_PERIOD_PS - 1) / `NV_CLK_PERIOD_PS)
`define NV_RECOVER_PS         700000
`define NV_RECOVER_CYC        ((`NV_RECOVER_PS + `NV_CLK_PERIOD_PS - 1) / `NV_CLK_PERIOD_PS)
`define NV_RECALL_PS          20000000
`define NV_RECALL_CYC         ((`NV_RECALL_PS + `NV_CLK_PERIOD_PS - 1) / `NV_CLK_PERIOD_PS)
`define NV_STORE_CYC_DEF      400000
`define NV_RESTORE_CYC_DEF    22000

`endif

// file: core/nvsram_ctrl_pkg.sv
package nvsram_ctrl_pkg;
    typedef enum logic [2:0] {
        CMD_READ     = 3'h0,
        CMD_WRITE    = 3'h1,
        CMD_SW_STORE = 3'h2,
        CMD_SW_RECALL= 3'h3,
        CMD_HW_STORE = 3'h4
    } cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_SETUP   = 4'h1,
        ST_STROBE  = 4'h2,
        ST_HOLD    = 4'h3,
        ST_HSB_REQ = 4'h4,
        ST_HSB_WT  = 4'h5,
        ST_HSB_BSY = 4'h6,
        ST_RECOVER = 4'h7,
        ST_NV_WAIT = 4'h8,
        ST_PWRUP   = 4'h9
    } state_t;
endpackage

// file: core/nvsram_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
// loadable down counter; done is high while the count is zero
module nvsram_cycle_timer (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        load,
    input  wire logic [19:0] value,
    output logic             done
);
    logic [19:0] count_reg;

    // reload wins over counting so a new wait always starts clean
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= 20'h00000;
        end else if (load) begin
            count_reg <= value;
        end else if (count_reg != 20'h00000) begin
            count_reg <= count_reg - 20'h00001;
        end
    end

    assign done = (count_reg == 20'h00000);
endmodule // nvsram_cycle_timer
`default_nettype wire

// file: core/nvsram_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvsram_ctrl_params.svh"
module nvsram_host_ctrl #(
    parameter int STORE_CYC   = `NV_STORE_CYC_DEF,
    parameter int RESTORE_CYC = `NV_RESTORE_CYC_DEF
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          req_valid,
    input  wire nvsram_ctrl_pkg::cmd_t         req_cmd,
    input  wire logic [`NV_ADDR_W-1:0]         req_addr,
    input  wire logic [`NV_DATA_W-1:0]         req_wdata,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output logic [`NV_DATA_W-1:0]              rsp_rdata,
    output logic                               rsp_skipped,
    output logic                               chip_select_n,
    output logic                               output_enable_n,
    output logic                               write_enable_n,
    output logic [`NV_ADDR_W-1:0]              byte_address,
    input  wire logic [`NV_DATA_W-1:0]         data_io_in,
    output logic [`NV_DATA_W-1:0]              data_io_out,
    output logic                               data_io_oe,
    input  wire logic                          store_busy_n_in,
    output logic                               store_busy_n_out,
    output logic                               store_busy_n_oe
);
    ////////////////////////////////////////////////////////////////////////////
    // sequence address table
    function automatic logic [`NV_ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                       input logic recall);
        logic [`NV_ADDR_W-1:0] a;
        a = `NV_SEQ_A0;
        case (step)
            3'h0:    a = `NV_SEQ_A0;
            3'h1:    a = `NV_SEQ_A1;
            3'h2:    a = `NV_SEQ_A2;
            3'h3:    a = `NV_SEQ_A3;
            3'h4:    a = `NV_SEQ_A4;
            default: a = recall ? `NV_SEQ_RECALL : `NV_SEQ_STORE;
        endcase
        return a & `NV_SEQ_MASK;
    endfunction

    nvsram_ctrl_pkg::state_t state_reg, state_next;
    nvsram_ctrl_pkg::cmd_t   cmd_reg;
    logic [2:0]              step_reg;
    logic                    dirty_reg;
    logic                    tmr_load;
    logic [19:0]             tmr_value;
    logic                    tmr_done;
    logic                    is_seq;
    logic                    seq_last;
    logic                    is_write;
    logic                    pwrup_reg;

    nvsram_cycle_timer u_timer (
        .clk   (clk),
        .rstn  (rstn),
        .load  (tmr_load),
        .value (tmr_value),
        .done  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode of the held command
    assign is_seq   = (cmd_reg == nvsram_ctrl_pkg::CMD_SW_STORE) ||
                      (cmd_reg == nvsram_ctrl_pkg::CMD_SW_RECALL);
    assign seq_last = is_seq && (step_reg == 3'(`NV_SEQ_LEN - 1));
    assign is_write = (cmd_reg == nvsram_ctrl_pkg::CMD_WRITE);

    // next state; a busy pin low from outside (power-fail store) stalls new requests
    always_comb begin
        state_next = state_reg;
        tmr_load   = 1'b0;
        tmr_value  = 20'h00000;
        case (state_reg)
            nvsram_ctrl_pkg::ST_PWRUP: begin
                // done already reads high out of reset, so the recall wait is loaded first
                if (pwrup_reg) begin
                    tmr_load   = 1'b1;
                    tmr_value  = 20'(RESTORE_CYC);
                end else if (tmr_done) begin
                    state_next = nvsram_ctrl_pkg::ST_IDLE;
                end
            end
            nvsram_ctrl_pkg::ST_IDLE: begin
                if (!store_busy_n_in) begin
                    state_next = nvsram_ctrl_pkg::ST_HSB_BSY;
                end else if (req_valid && req_cmd == nvsram_ctrl_pkg::CMD_HW_STORE) begin
                    state_next = nvsram_ctrl_pkg::ST_HSB_REQ;
                    tmr_load   = 1'b1;
                    tmr_value  = 20'(`NV_HSB_PULSE_CYC);
                end else if (req_valid) begin
                    state_next = nvsram_ctrl_pkg::ST_SETUP;
                    tmr_load   = 1'b1;
                    tmr_value  = 20'(`NV_SETUP_CYC);
                end
            end
            nvsram_ctrl_pkg::ST_SETUP: begin
                if (tmr_done) begin
                    state_next = nvsram_ctrl_pkg::ST_STROBE;
                    tmr_load   = 1'b1;
                    tmr_value  = 20'(`NV_STROBE_CYC);
                end
            end
            nvsram_ctrl_pkg::ST_STROBE: begin
                if (tmr_done) begin
                    state_next = nvsram_ctrl_pkg::ST_HOLD;
                end
            end
            nvsram_ctrl_pkg::ST_HOLD: begin
                if (!is_seq || !seq_last) begin
                    state_next = is_seq ? nvsram_ctrl_pkg::ST_SETUP
                                        : nvsram_ctrl_pkg::ST_IDLE;
                    tmr_load   = is_seq;
                    tmr_value  = 20'(`NV_SETUP_CYC);
                end else begin
                    state_next = nvsram_ctrl_pkg::ST_NV_WAIT;
                    tmr_load   = 1'b1;
                    tmr_value  = (cmd_reg == nvsram_ctrl_pkg::CMD_SW_STORE)
                                 ? 20'(STORE_CYC) : 20'(`NV_RECALL_CYC);
                end
            end
            nvsram_ctrl_pkg::ST_HSB_REQ: begin
                if (tmr_done) begin
                    state_next = nvsram_ctrl_pkg::ST_HSB_WT;
                    tmr_load   = 1'b1;
                    tmr_value  = 20'(`NV_GRACE_CYC);
                end
            end
            nvsram_ctrl_pkg::ST_HSB_WT: begin
                // skipped store: device never drives the pin
                if (tmr_done) begin
                    state_next = nvsram_ctrl_pkg::ST_RECOVER;
                    tmr_load   = 1'b1;
                    tmr_value  = 20'(`NV_RECOVER_CYC);
                end else if (!store_busy_n_in) begin
                    state_next = nvsram_ctrl_pkg::ST_HSB_BSY;
                end
            end
            nvsram_ctrl_pkg::ST_HSB_BSY: begin
                if (store_busy_n_in) begin
                    state_next = nvsram_ctrl_pkg::ST_RECOVER;
                    tmr_load   = 1'b1;
                    tmr_value  = 20'(`NV_RECOVER_CYC);
                end
            end
            nvsram_ctrl_pkg::ST_RECOVER,
            nvsram_ctrl_pkg::ST_NV_WAIT: begin
                if (tmr_done) begin
                    state_next = nvsram_ctrl_pkg::ST_IDLE;
                end
            end
            default: state_next = nvsram_ctrl_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state, command and sequence step
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= nvsram_ctrl_pkg::ST_PWRUP;
            cmd_reg   <= nvsram_ctrl_pkg::CMD_READ;
            step_reg  <= 3'h0;
            pwrup_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            pwrup_reg <= 1'b0;
            if (state_reg == nvsram_ctrl_pkg::ST_IDLE && state_next == nvsram_ctrl_pkg::ST_SETUP) begin
                cmd_reg  <= req_cmd;
                step_reg <= 3'h0;
            end else if (state_reg == nvsram_ctrl_pkg::ST_HOLD && is_seq) begin
                step_reg <= step_reg + 3'h1;
            end
        end
    end

    // hold the address per step; plain reads and writes use all fifteen bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byte_address <= '0;
            data_io_out  <= '0;
        end else if (state_reg == nvsram_ctrl_pkg::ST_IDLE && state_next == nvsram_ctrl_pkg::ST_SETUP) begin
            byte_address <= (req_cmd == nvsram_ctrl_pkg::CMD_SW_STORE ||
                             req_cmd == nvsram_ctrl_pkg::CMD_SW_RECALL)
                            ? seq_addr(3'h0, 1'b0) : req_addr;
            data_io_out  <= req_wdata;
        end else if (state_reg == nvsram_ctrl_pkg::ST_HOLD && is_seq && !seq_last) begin
            // address moves only with select high
            byte_address <= seq_addr(step_reg + 3'h1,
                                     cmd_reg == nvsram_ctrl_pkg::CMD_SW_RECALL);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin strobes, all registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chip_select_n   <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n  <= 1'b1;
            data_io_oe      <= 1'b0;
        end else begin
            chip_select_n   <= !(state_next == nvsram_ctrl_pkg::ST_STROBE);
            output_enable_n <= !(state_next == nvsram_ctrl_pkg::ST_STROBE &&
                                 (cmd_reg == nvsram_ctrl_pkg::CMD_READ));
            write_enable_n  <= !(state_next == nvsram_ctrl_pkg::ST_STROBE && is_write);
            data_io_oe      <= (state_next == nvsram_ctrl_pkg::ST_STROBE ||
                                state_next == nvsram_ctrl_pkg::ST_SETUP) && is_write;
        end
    end

    // hardware request drives the open-drain pin for the pulse width only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            store_busy_n_out <= 1'b1;
            store_busy_n_oe  <= 1'b0;
        end else begin
            store_busy_n_out <= 1'b0;
            store_busy_n_oe  <= (state_next == nvsram_ctrl_pkg::ST_HSB_REQ);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer; read data taken at end of strobe while address held
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid   <= 1'b0;
            rsp_rdata   <= '0;
            rsp_skipped <= 1'b0;
            dirty_reg   <= 1'b0;
            req_ready   <= 1'b0;
        end else begin
            req_ready   <= (state_next == nvsram_ctrl_pkg::ST_IDLE) && store_busy_n_in;
            rsp_valid   <= 1'b0;
            if (state_reg == nvsram_ctrl_pkg::ST_STROBE && tmr_done) begin
                rsp_rdata <= data_io_in;
            end
            if (state_reg == nvsram_ctrl_pkg::ST_HOLD && (!is_seq || seq_last)) begin
                rsp_valid <= !is_seq;
            end
            if (state_reg == nvsram_ctrl_pkg::ST_NV_WAIT && tmr_done) begin
                rsp_valid <= 1'b1;
            end
            if (state_reg == nvsram_ctrl_pkg::ST_HOLD && is_write) begin
                dirty_reg <= 1'b1;
            end else if ((state_reg == nvsram_ctrl_pkg::ST_HOLD && seq_last) ||
                         state_reg == nvsram_ctrl_pkg::ST_HSB_BSY) begin
                dirty_reg <= 1'b0;
            end
            if (state_reg == nvsram_ctrl_pkg::ST_RECOVER && tmr_done) begin
                rsp_valid   <= 1'b1;
            end
            // prediction taken at the request, before the busy phase clears the dirty flag
            if (state_reg == nvsram_ctrl_pkg::ST_IDLE &&
                state_next == nvsram_ctrl_pkg::ST_HSB_REQ) begin
                rsp_skipped <= !dirty_reg;
            end else if (state_reg == nvsram_ctrl_pkg::ST_IDLE && req_valid) begin
                rsp_skipped <= 1'b0;
            end
        end
    end
endmodule // nvsram_host_ctrl
`default_nettype wire

// file: tb/nvsram_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural memory; clock cycles stand in for the analogue delays
module nvsram_dev_model #(
    parameter int GRACE  = 40,
    parameter int STORE  = 60,
    parameter int RECALL = 30
) (
    input  wire logic        clk,
    input  wire logic        pwr_fail,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out,
    output logic             dq_oe,
    input  wire logic        busy_in,
    output logic             pull = 1'b0,
    output int               stores = 0,
    output int               recalls = 0
);
    logic [7:0]  sram [32768] = '{default: 8'h00};
    logic [7:0]  nv   [32768] = '{default: 8'h00};
    logic [13:0] seq  [7] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F, 14'h0FC0, 14'h0C63};
    logic        dirty = 1'b0, hw = 1'b0, cs_q = 1'b1;
    int          step = 0, cnt = 0, nvb = 8;
    wire logic   ok = nvb == 0 && (!hw || cnt > STORE);
    ////////////////////////////////////////////////////////////////
    // released lines show the inverse byte so a stale value never passes
    assign dq_oe  = !cs_n && !oe_n && we_n && busy_in && ok;
    assign dq_out = dq_oe ? sram[addr] : ~sram[addr];
    // one process keeps access, sequence and store timing in a fixed order
    always @(posedge clk) begin
        cs_q <= cs_n;
        if (nvb > 0) nvb <= nvb - 1;
        if (nvb == 1 && !hw) pull <= 1'b0;
        if (cnt > 0) cnt <= cnt - 1;
        if (!cs_n && !we_n && busy_in && ok) begin
            sram[addr] <= dq_in;
            dirty <= 1'b1;
        end
        if (!hw && nvb == 0 && (!busy_in || pwr_fail)) begin
            hw <= 1'b1;
            pull <= dirty || pwr_fail;
            cnt <= dirty ? GRACE + STORE : GRACE;
        end else if (hw && cnt == 1) begin
            pull <= 1'b0;
            if (dirty) begin
                stores <= stores + 1;
                dirty <= 1'b0;
                nv = sram;
            end
        end else if (hw && cnt == 0 && busy_in) begin
            hw <= 1'b0;
            nvb <= 4;
        end
        if (cs_q && !cs_n && ok) begin
            if (!we_n) step <= 0;
            else if (step == 5 && addr[13:0] == seq[5]) begin
                nvb <= STORE;
                pull <= 1'b1;
                stores <= stores + 1;
                dirty <= 1'b0;
                step <= 0;
                nv = sram;
            end else if (step == 5 && addr[13:0] == seq[6]) begin
                nvb <= RECALL;
                recalls <= recalls + 1;
                dirty <= 1'b0;
                step <= 0;
                sram = nv;
            end else if (addr[13:0] == seq[step]) step <= step + 1;
            else step <= addr[13:0] == seq[0] ? 1 : 0;
        end
    end
endmodule // nvsram_dev_model
`default_nettype wire

// file: tb/nvsram_host_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module nvsram_host_ctrl_sva #(
    parameter int STORE_CYC   = 50,
    parameter int RESTORE_CYC = 10
) (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  req_valid,
    input wire nvsram_ctrl_pkg::cmd_t req_cmd,
    input wire logic                  req_ready,
    input wire logic                  rsp_valid,
    input wire logic                  chip_select_n,
    input wire logic                  output_enable_n,
    input wire logic                  write_enable_n,
    input wire logic [14:0]           byte_address,
    input wire logic                  data_io_oe,
    input wire logic                  store_busy_n_in,
    input wire logic                  store_busy_n_out,
    input wire logic                  store_busy_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic take = req_valid && req_ready;
    wire logic sw_take = take && req_cmd inside {nvsram_ctrl_pkg::CMD_SW_STORE,
                                                 nvsram_ctrl_pkg::CMD_SW_RECALL};
    logic sw_on;
    int   up;
    ////////////////////////////////////////////////////////////////
    // sequence window and post-reset age; capped so the counter never wraps
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sw_on <= 1'b0;
            up <= 0;
        end else begin
            sw_on <= sw_take || (sw_on && !rsp_valid);
            up <= (up < 1000) ? up + 1 : up;
        end
    end
    sequence first_step;
        $fell(chip_select_n) && byte_address[13:0] == 14'h0E38;
    endsequence
    sequence held_cycle;
        !chip_select_n && !$past(chip_select_n);
    endsequence
    sequence req_low_pulse;
        !store_busy_n_out ##1 store_busy_n_oe ##1 !store_busy_n_oe;
    endsequence
    seq_start_a: assert property (sw_take |-> ##[1:6] first_step)
        else $error("sequence did not open at first address");
    reads_only_a: assert property (sw_on |-> write_enable_n)
        else $error("write strobe during sequence");
    addr_stable_a: assert property (held_cycle |-> $stable(byte_address))
        else $error("address moved inside access");
    oe_off_write_a: assert property (!write_enable_n |-> output_enable_n)
        else $error("output enable low in write");
    drive_gate_a: assert property (data_io_oe |-> output_enable_n)
        else $error("data driven against output enable");
    write_gate_a: assert property ($fell(write_enable_n) |-> store_busy_n_in)
        else $error("write started while busy low");
    read_mode_a: assert property ($fell(output_enable_n) |-> !chip_select_n && write_enable_n)
        else $error("read strobes wrong");
    req_pulse_a: assert property ($rose(store_busy_n_oe) |-> req_low_pulse)
        else $error("store request pulse malformed");
    hw_req_a: assert property (take && req_cmd == nvsram_ctrl_pkg::CMD_HW_STORE
        |-> ##[1:2] store_busy_n_oe)
        else $error("store request not issued");
    busy_hold_a: assert property (!store_busy_n_in [*4] |-> !req_ready)
        else $error("ready while busy low");
    recall_wait_a: assert property (up < RESTORE_CYC - 2 |-> !req_ready)
        else $error("ready during power-up recall");
endmodule // nvsram_host_ctrl_sva
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {nvsram_ctrl_pkg::cmd_t c; logic [14:0] a; logic [7:0] d;} row_t;
    localparam nvsram_ctrl_pkg::cmd_t WR = nvsram_ctrl_pkg::CMD_WRITE;
    localparam nvsram_ctrl_pkg::cmd_t RD = nvsram_ctrl_pkg::CMD_READ;
    localparam nvsram_ctrl_pkg::cmd_t HS = nvsram_ctrl_pkg::CMD_HW_STORE;
    // 7FFF and 3FFF differ only in the top bit, so aliasing shows
    row_t rows [6] = '{'{WR, 15'h0000, 8'h5A}, '{WR, 15'h7FFF, 8'hA5}, '{WR, 15'h3FFF, 8'h3C},
                       '{RD, 15'h0000, 8'h5A}, '{RD, 15'h7FFF, 8'hA5}, '{RD, 15'h3FFF, 8'h3C}};
    logic        clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, pwr_fail = 1'b0;
    logic [14:0] req_addr = 15'h0000, byte_address;
    logic [7:0]  req_wdata = 8'h00, rsp_rdata, data_io_out, m_out;
    logic        req_ready, rsp_valid, rsp_skipped, chip_select_n, output_enable_n, m_oe;
    logic        write_enable_n, data_io_oe, store_busy_n_out, store_busy_n_oe, m_pull;
    int          fails = 0, checked = 0, stores, recalls, s0;
    nvsram_ctrl_pkg::cmd_t req_cmd = RD;
    wire logic [7:0] dq_bus = data_io_oe ? data_io_out : m_out;
    // pull-up on the open-drain busy line
    wire logic   pin = !((store_busy_n_oe && !store_busy_n_out) || m_pull);
    always #12.5 clk = ~clk;
    nvsram_host_ctrl #(.STORE_CYC(50), .RESTORE_CYC(10)) nvsram_host_ctrl_inst (
        .clk(clk), .rstn(rstn), .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_skipped(rsp_skipped), .chip_select_n(chip_select_n),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
        .byte_address(byte_address), .data_io_in(dq_bus), .data_io_out(data_io_out),
        .data_io_oe(data_io_oe), .store_busy_n_in(pin), .store_busy_n_out(store_busy_n_out),
        .store_busy_n_oe(store_busy_n_oe));
    // model store kept inside the host's store wait, as the device's maximum allows
    nvsram_dev_model #(.STORE(40)) nvsram_dev_model_inst (
        .clk(clk), .pwr_fail(pwr_fail), .cs_n(chip_select_n), .oe_n(output_enable_n),
        .we_n(write_enable_n), .addr(byte_address), .dq_in(dq_bus), .dq_out(m_out),
        .dq_oe(m_oe), .busy_in(pin), .pull(m_pull), .stores(stores), .recalls(recalls));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 3000) begin
                fails++;
                print_verdict();
            end
        end
    endtask
    task automatic run(input nvsram_ctrl_pkg::cmd_t c, input logic [14:0] a, input logic [7:0] d);
        wait_hi(req_ready);
        @(posedge clk);
        req_cmd <= c;
        req_addr <= a;
        req_wdata <= d;
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        wait_hi(rsp_valid);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1;
        chk("ready in reset", req_ready, 1'b0);
        chk("select in reset", chip_select_n, 1'b1);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("ready in recall", req_ready, 1'b0);
        foreach (rows[i]) begin
            run(rows[i].c, rows[i].a, rows[i].d);
            if (rows[i].c == RD) chk("read data", rsp_rdata, rows[i].d);
        end
        // software store, then a write that the recall must undo
        s0 = stores;
        run(nvsram_ctrl_pkg::CMD_SW_STORE, 15'h0000, 8'h00);
        chk("soft store", stores, s0 + 1);
        run(WR, 15'h0000, 8'hC3);
        run(nvsram_ctrl_pkg::CMD_SW_RECALL, 15'h0000, 8'h00);
        chk("soft recall", recalls, 1);
        run(RD, 15'h0000, 8'h00);
        chk("recalled data", rsp_rdata, 8'h5A);
        // hardware store when dirty, then again when clean
        run(WR, 15'h0001, 8'h11);
        run(HS, 15'h0000, 8'h00);
        chk("hw store", stores, s0 + 2);
        chk("hw not skipped", rsp_skipped, 1'b0);
        run(HS, 15'h0000, 8'h00);
        chk("hw skipped", rsp_skipped, 1'b1);
        chk("no clean store", stores, s0 + 2);
        // power failure while dirty takes the line from the host
        run(WR, 15'h0002, 8'h96);
        @(posedge clk);
        pwr_fail <= 1'b1;
        @(posedge clk);
        pwr_fail <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("ready in power fail", req_ready, 1'b0);
        run(RD, 15'h0002, 8'h00);
        chk("data after store", rsp_rdata, 8'h96);
        chk("power fail store", stores, s0 + 3);
        print_verdict();
    end
endmodule // tb_top
bind nvsram_host_ctrl nvsram_host_ctrl_sva #(.STORE_CYC(STORE_CYC), .RESTORE_CYC(RESTORE_CYC))
    nvsram_host_ctrl_sva_inst (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .byte_address(byte_address), .data_io_oe(data_io_oe),
    .store_busy_n_in(store_busy_n_in), .store_busy_n_out(store_busy_n_out),
    .store_busy_n_oe(store_busy_n_oe));
`default_nettype wire
